// *** design/ctw_defines.svh ***
/*
 * Constants of the coincidence trigger: command indices, reset values, field positions
 * and tick timing. Assumes a 100 MHz board clock and the ctw_pkg types alongside.
 */
`ifndef CTW_DEFINES_SVH
`define CTW_DEFINES_SVH
`define CTW_CLK_NS      10
`define CTW_TICK_NS     24
`define CTW_TICK_CYC    ((`CTW_TICK_NS + `CTW_CLK_NS - 1) / `CTW_CLK_NS)
`define CTW_IDX_CTRL0   8'h00
`define CTW_IDX_RPTR    8'h01
`define CTW_IDX_WPTR    8'h02
`define CTW_IDX_WLO     8'h02
`define CTW_IDX_WHI     8'h03
`define CTW_CTRL0_RST   8'h1F
`define CTW_RPTR_RST    8'h00
`define CTW_WPTR_RST    8'h06
`define CTW_WLO_RST     8'h0A
`define CTW_WHI_RST     8'h00
`define CTW_PTR_MASK    8'h7F
`define CTW_WIN_DEF     8'h06
`define CTW_WIDTH_DEF   16'h000A
`define CTW_LVL_MSB     7
`define CTW_LVL_LSB     4
`define CTW_EN_MSB      3
`define CTW_EN_LSB      0
`define CTW_REP_LAST    3'h4
`define CTW_FIFO_DEPTH  8
`endif

// *** design/ctw_pkg.sv ***
/*
 * Types of the coincidence trigger: states, host commands, output words.
 * Assumes the host text parser delivers one decoded command per handshake.
 */
package ctw_pkg;
    typedef enum logic [2:0] {
        OP_NONE, OP_RESET, OP_DISABLE, OP_ENABLE, OP_DISPLAY, OP_WCTRL, OP_WTIME
    } ctw_op_t;

    typedef enum logic [1:0] {
        ST_IDLE, ST_WINDOW, ST_RECORD, ST_REPORT
    } ctw_state_t;

    typedef enum logic [1:0] {
        KIND_EDGE, KIND_SCALER, KIND_COINC, KIND_SPARE
    } ctw_kind_t;

    typedef struct packed {
        ctw_op_t    op;
        logic [7:0] idx;
        logic [7:0] val;
    } ctw_cmd_t;

    // edge word: aux = {trigger tag, rise[3:0], fall[3:0]}, data = tick offset
    // scaler word: aux = channel index, data = count
    typedef struct packed {
        ctw_kind_t   kind;
        logic [8:0]  aux;
        logic [20:0] data;
    } ctw_word_t;
endpackage

// *** design/ctw_sync.sv ***
/*
 * Three-stage pin synchroniser with agreement filter, one lane per channel.
 * Assumes asynchronous pulse inputs and a shared clock enable.
 */
`timescale 1ns/1ps
module ctw_sync #(
    parameter int N = 4
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic         ce_i,
    input  wire logic [N-1:0] pin_i,
    output logic      [N-1:0] level_o
);
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_lane
            logic s1_r, s2_r, s3_r, lvl_r;
            // stage one feeds stage two only; the filter looks at two and three
            always_ff @(posedge clock_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    s1_r  <= 1'b0;
                    s2_r  <= 1'b0;
                    s3_r  <= 1'b0;
                    lvl_r <= 1'b0;
                end
                else if (ce_i)
                begin
                    s1_r <= pin_i[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    if (s2_r == s3_r)
                        lvl_r <= s3_r;
                end
            end
            assign level_o[i] = lvl_r;
        end
    endgenerate
endmodule

// *** design/ctw_fifo.sv ***
/*
 * Flip-flop FIFO with valid/ready on both sides and honest full/empty.
 * Assumes depth is a power of two; clock enable freezes everything.
 */
`timescale 1ns/1ps
`include "ctw_defines.svh"
module ctw_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = `CTW_FIFO_DEPTH
) (
    input  wire logic             clock_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wr_r;
    logic [AW-1:0]    rd_r;
    logic [AW:0]      cnt_r;
    wire              push = in_valid_i && in_ready_o && ce_i;
    wire              pop  = out_valid_o && out_ready_i && ce_i;

    assign in_ready_o  = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_r != '0);
    assign out_data_o  = mem_r[rd_r];

    always_ff @(posedge clock_i)
    begin
        if (push)
            mem_r[wr_r] <= in_data_i;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r  <= push ? wr_r + 1'b1 : wr_r;
            rd_r  <= pop ? rd_r + 1'b1 : rd_r;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** design/ctw_core.sv ***
/*
 * Coincidence trigger core: host command decode, control and time registers,
 * coincidence window, edge recording, scalers and scaler report stream.
 * Assumes commands arrive already parsed from the host text line, and that the
 * word sink drains the output FIFO.
 */
`timescale 1ns/1ps
`include "ctw_defines.svh"
module ctw_core (
    input  wire logic              clock_i,
    input  wire logic              rst_i,
    input  wire logic              ce_i,
    input  wire logic [3:0]        chan_i,
    input  wire logic              cmd_valid_i,
    input  wire ctw_pkg::ctw_cmd_t cmd_i,
    output logic                   cmd_ready_o,
    output logic                   trigger_o,
    output logic                   busy_o,
    output logic                   counting_o,
    output logic                   lost_o,
    output logic                   word_valid_o,
    output ctw_pkg::ctw_word_t     word_o,
    input  wire logic              word_ready_i
);
    // ******************************************************
    // declarations
    // ******************************************************
    localparam logic [1:0] TICK_LAST = 2'(`CTW_TICK_CYC - 1);

    ctw_pkg::ctw_state_t state_r;
    ctw_pkg::ctw_state_t state_nxt;
    ctw_pkg::ctw_word_t  push_word;
    logic [7:0]          ctrl0_r;
    logic [7:0]          rptr_r;
    logic [7:0]          wptr_r;
    logic [7:0]          wlo_r;
    logic [7:0]          whi_r;
    logic                run_r;
    logic                rep_pend_r;
    logic [2:0]          rep_idx_r;
    logic [1:0]          pre_r;
    logic [15:0]         tick_cnt_r;
    logic [3:0]          hit_r;
    logic [3:0]          fall_acc_r;
    logic [3:0]          prev_r;
    logic [3:0]          lvl_w;
    logic [20:0]         coinc_r;
    logic                lost_r;
    logic                trig_r;
    logic                fifo_ready;
    logic                push_edge;
    logic [20:0]         scal_w [4];

    function automatic logic [2:0] ones4(input logic [3:0] v);
        ones4 = 3'(v[0]) + 3'(v[1]) + 3'(v[2]) + 3'(v[3]);
    endfunction

    // ******************************************************
    // command decode
    // ******************************************************
    wire cmd_take   = cmd_valid_i && cmd_ready_o;
    wire do_reset   = cmd_take && (cmd_i.op == ctw_pkg::OP_RESET);
    wire do_disable = cmd_take && (cmd_i.op == ctw_pkg::OP_DISABLE);
    wire do_enable  = cmd_take && (cmd_i.op == ctw_pkg::OP_ENABLE);
    wire do_display = cmd_take && (cmd_i.op == ctw_pkg::OP_DISPLAY);
    wire do_wctrl   = cmd_take && (cmd_i.op == ctw_pkg::OP_WCTRL);
    wire do_wtime   = cmd_take && (cmd_i.op == ctw_pkg::OP_WTIME);
    wire wr_ctrl0   = do_wctrl && (cmd_i.idx == `CTW_IDX_CTRL0);
    wire wr_wlo     = do_wctrl && (cmd_i.idx == `CTW_IDX_WLO);
    wire wr_whi     = do_wctrl && (cmd_i.idx == `CTW_IDX_WHI);
    wire wr_rptr    = do_wtime && (cmd_i.idx == `CTW_IDX_RPTR);
    wire wr_wptr    = do_wtime && (cmd_i.idx == `CTW_IDX_WPTR);

    // report stalls new commands so a display is never half overwritten
    assign cmd_ready_o = (state_r != ctw_pkg::ST_REPORT);

    // ******************************************************
    // settings
    // ******************************************************
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            ctrl0_r <= `CTW_CTRL0_RST;
            rptr_r  <= `CTW_RPTR_RST;
            wptr_r  <= `CTW_WPTR_RST;
            wlo_r   <= `CTW_WLO_RST;
            whi_r   <= `CTW_WHI_RST;
        end
        else if (ce_i && do_reset)
        begin
            ctrl0_r <= `CTW_CTRL0_RST;
            rptr_r  <= `CTW_RPTR_RST;
            wptr_r  <= `CTW_WPTR_RST;
            wlo_r   <= `CTW_WLO_RST;
            whi_r   <= `CTW_WHI_RST;
        end
        else if (ce_i)
        begin
            ctrl0_r <= wr_ctrl0 ? cmd_i.val : ctrl0_r;
            wlo_r   <= wr_wlo ? cmd_i.val : wlo_r;
            whi_r   <= wr_whi ? cmd_i.val : whi_r;
            rptr_r  <= wr_rptr ? cmd_i.val : rptr_r;
            wptr_r  <= wr_wptr ? cmd_i.val : wptr_r;
        end
    end

    // too-short windows are the host's problem; hardware just obeys them
    wire [7:0]  win_ticks   = (wptr_r - rptr_r) & `CTW_PTR_MASK;
    wire [15:0] width_ticks = {whi_r, wlo_r};
    wire [3:0]  level       = ctrl0_r[`CTW_LVL_MSB:`CTW_LVL_LSB];
    wire [3:0]  en_mask     = ctrl0_r[`CTW_EN_MSB:`CTW_EN_LSB];
    wire [4:0]  need        = {1'b0, level} + 5'h01;

    // ******************************************************
    // pulse edges
    // ******************************************************
    ctw_sync #(
        .N (4)
    ) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .ce_i    (ce_i),
        .pin_i   (chan_i),
        .level_o (lvl_w)
    );

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
            prev_r <= 4'h0;
        else if (ce_i)
            prev_r <= lvl_w;
    end

    wire [3:0] rise       = lvl_w & ~prev_r;
    wire [3:0] fall       = ~lvl_w & prev_r;
    wire [3:0] start_hits = rise & en_mask & {4{run_r}};
    wire       in_idle    = (state_r == ctw_pkg::ST_IDLE);
    wire       in_window  = (state_r == ctw_pkg::ST_WINDOW);
    wire       in_record  = (state_r == ctw_pkg::ST_RECORD);
    wire       in_report  = (state_r == ctw_pkg::ST_REPORT);
    wire [3:0] hits_nxt   = in_idle ? start_hits : (hit_r | start_hits);
    wire [3:0] falls_nxt  = in_idle ? fall : (fall_acc_r | fall);
    wire       coinc_ok   = ({2'b00, ones4(hits_nxt)} >= need);
    wire       tick       = (pre_r == TICK_LAST);
    wire       expired    = (tick_cnt_r >= {8'h00, win_ticks});
    wire       rec_done   = (tick_cnt_r >= width_ticks);

    wire start    = in_idle && !rep_pend_r && (|start_hits);
    wire fire_idl = start && coinc_ok;
    wire fire_win = in_window && run_r && !expired && coinc_ok;
    wire trig_fire = fire_idl || fire_win;

    // ******************************************************
    // coincidence state machine
    // ******************************************************
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ctw_pkg::ST_IDLE:
                if (rep_pend_r)
                    state_nxt = ctw_pkg::ST_REPORT;
                else if (fire_idl)
                    state_nxt = ctw_pkg::ST_RECORD;
                else if (start)
                    state_nxt = ctw_pkg::ST_WINDOW;
            ctw_pkg::ST_WINDOW:
                if (!run_r || expired)
                    state_nxt = ctw_pkg::ST_IDLE;
                else if (coinc_ok)
                    state_nxt = ctw_pkg::ST_RECORD;
            ctw_pkg::ST_RECORD:
                if (!run_r || rec_done)
                    state_nxt = ctw_pkg::ST_IDLE;
            ctw_pkg::ST_REPORT:
                if (fifo_ready && rep_idx_r == `CTW_REP_LAST)
                    state_nxt = ctw_pkg::ST_IDLE;
            default:
                state_nxt = ctw_pkg::ST_IDLE;
        endcase
        if (do_reset)
            state_nxt = ctw_pkg::ST_IDLE;
    end

    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r    <= ctw_pkg::ST_IDLE;
            pre_r      <= 2'h0;
            tick_cnt_r <= 16'h0000;
            hit_r      <= 4'h0;
            fall_acc_r <= 4'h0;
            trig_r     <= 1'b0;
        end
        else if (ce_i)
        begin
            state_r    <= state_nxt;
            trig_r     <= trig_fire;
            hit_r      <= hits_nxt;
            fall_acc_r <= falls_nxt;
            // whole ticks counted from the first qualifying pulse
            pre_r      <= (start || tick) ? 2'h0 : pre_r + 2'h1;
            if (start)
                tick_cnt_r <= 16'h0000;
            else if (tick && tick_cnt_r != 16'hFFFF)
                tick_cnt_r <= tick_cnt_r + 16'h0001;
        end
    end

    // ******************************************************
    // run control, scalers, report
    // ******************************************************
    always_ff @(posedge clock_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            run_r      <= 1'b1;
            rep_pend_r <= 1'b0;
            rep_idx_r  <= 3'h0;
            coinc_r    <= 21'h000000;
            lost_r     <= 1'b0;
        end
        else if (ce_i)
        begin
            if (do_disable)
                run_r <= 1'b0;
            else if (do_enable || do_reset)
                run_r <= 1'b1;
            rep_pend_r <= do_display || (rep_pend_r && !in_idle);
            if (!in_report)
                rep_idx_r <= 3'h0;
            else if (fifo_ready)
                rep_idx_r <= rep_idx_r + 3'h1;
            if (do_reset)
                coinc_r <= 21'h000000;
            else if (trig_fire)
                coinc_r <= coinc_r + 21'h000001;
            // overflow flag: a new drop beats the reset command's clear
            lost_r <= (lost_r && !do_reset) || (push_edge && !fifo_ready);
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++)
        begin : g_scal
            logic [20:0] cnt_r;
            always_ff @(posedge clock_i or posedge rst_i)
            begin
                if (rst_i)
                    cnt_r <= 21'h000000;
                else if (ce_i && do_reset)
                    cnt_r <= 21'h000000;
                else if (ce_i && run_r && rise[ch])
                    cnt_r <= cnt_r + 21'h000001;
            end
            assign scal_w[ch] = cnt_r;
        end
    endgenerate

    // ******************************************************
    // output words
    // ******************************************************
    wire rec_edge  = in_record && run_r && !rec_done && (|(rise | fall));
    assign push_edge = trig_fire || rec_edge;
    wire last_rep  = (rep_idx_r == `CTW_REP_LAST);
    wire push_any  = push_edge || in_report;
    wire [20:0] rep_data = last_rep ? coinc_r : scal_w[rep_idx_r[1:0]];

    always_comb
    begin
        push_word.kind = ctw_pkg::KIND_EDGE;
        push_word.aux  = {trig_fire, hits_nxt | (rise & ~en_mask), falls_nxt};
        push_word.data = {5'h00, tick_cnt_r};
        if (rec_edge && !trig_fire)
            push_word.aux = {1'b0, rise, fall};
        if (in_report)
        begin
            push_word.kind = last_rep ? ctw_pkg::KIND_COINC : ctw_pkg::KIND_SCALER;
            push_word.aux  = {6'h00, rep_idx_r};
            push_word.data = rep_data;
        end
    end

    ctw_fifo #(
        .WIDTH ($bits(ctw_pkg::ctw_word_t)),
        .DEPTH (`CTW_FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .in_valid_i  (push_any),
        .in_data_i   (push_word),
        .in_ready_o  (fifo_ready),
        .out_valid_o (word_valid_o),
        .out_data_o  (word_o),
        .out_ready_i (word_ready_i)
    );

    assign trigger_o  = trig_r;
    assign busy_o     = !in_idle;
    assign counting_o = run_r;
    assign lost_o     = lost_r;

    // ******************************************************
    // checks
    // ******************************************************
    sequence s_disabled;
        !run_r ##0 !trig_fire;
    endsequence

    sequence s_report_start;
        ##2 in_report;
    endsequence

    property p_trig_enabled;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        trig_fire |-> ((hits_nxt & ~en_mask) == 4'h0) && (ones4(hits_nxt) != 3'h0);
    endproperty
    a_trig_enabled: assert property (p_trig_enabled) else $error("trigger from disabled channel");

    property p_window_expiry;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        (in_window && tick_cnt_r >= {8'h00, win_ticks}) |-> !trig_fire ##1 in_idle;
    endproperty
    a_window_expiry: assert property (p_window_expiry) else $error("late pulse triggered");

    property p_record_edge;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        (in_record && run_r && tick_cnt_r < width_ticks && (|rise)) |-> push_any;
    endproperty
    a_record_edge: assert property (p_record_edge) else $error("edge not recorded");

    property p_power_up;
        @(posedge clock_i) $fell(rst_i) |->
            (win_ticks == `CTW_WIN_DEF) && (width_ticks == `CTW_WIDTH_DEF);
    endproperty
    a_power_up: assert property (p_power_up) else $error("bad power-up windows");

    property p_card_reset;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        do_reset |=> (coinc_r == 21'h000000) && (scal_w[0] == 21'h000000)
            && (ctrl0_r == `CTW_CTRL0_RST) && (win_ticks == `CTW_WIN_DEF) && in_idle;
    endproperty
    a_card_reset: assert property (p_card_reset) else $error("card reset incomplete");

    property p_disable;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        (do_disable ##1 !do_enable && !do_reset) |-> s_disabled;
    endproperty
    a_disable: assert property (p_disable) else $error("counting after disable");

    property p_enable;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        do_enable |=> run_r;
    endproperty
    a_enable: assert property (p_enable) else $error("enable did not restart");

    property p_ptr_window;
        @(posedge clock_i) disable iff (rst_i)
        wr_wptr |=> win_ticks == {1'b0, 7'($past(cmd_i.val) - rptr_r)};
    endproperty
    a_ptr_window: assert property (p_ptr_window) else $error("window above 7F");

    property p_ctrl_write;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        wr_ctrl0 |=> level == $past(cmd_i.val[7:4]) && en_mask == $past(cmd_i.val[3:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_singles;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        (level == 4'h0 && start) |-> trig_fire ##1 trigger_o;
    endproperty
    a_singles: assert property (p_singles) else $error("singles did not trigger");

    property p_display;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        (do_display && in_idle && !start) |-> s_report_start;
    endproperty
    a_display: assert property (p_display) else $error("report did not start");

    property p_coinc_word;
        @(posedge clock_i) disable iff (rst_i || !ce_i)
        (in_report && last_rep) |-> push_word.kind == ctw_pkg::KIND_COINC
            && push_word.data == coinc_r;
    endproperty
    a_coinc_word: assert property (p_coinc_word) else $error("coincidence word wrong");
endmodule

// *** verif/ctw_host_model.sv ***
/* host side: sends one parsed command per handshake.
   assumes ctw_pkg compiled first, one clock. */
`timescale 1ns/1ps
module ctw_host_model (
    input  wire logic         clock_i,
    input  wire logic         cmd_ready_i,
    output logic              cmd_valid_o,
    output ctw_pkg::ctw_cmd_t cmd_o
);
    // ****************
    // command driver
    // ****************
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_o = '0;
    end
    // windows kept at two ticks or more, and small
    task automatic send(input ctw_pkg::ctw_op_t op, input logic [7:0] idx, val);
        cmd_valid_o <= 1'b1;
        cmd_o <= '{op, idx, val};
        @(posedge clock_i iff cmd_ready_i === 1'b1);
        cmd_valid_o <= 1'b0;
        cmd_o <= '{ctw_pkg::OP_NONE, ~idx, ~val};
        @(posedge clock_i);
    endtask
endmodule

// *** verif/coincidence_trigger_window_config_tb_top.sv ***
/* bench for ctw_core: pulses, commands, report stream.
   assumes ctw_host_model and the design compiled first. */
`timescale 1ns/1ps
module coincidence_trigger_window_config_tb_top;
    logic clock_i = 0, rst_i = 1, ce_i = 1, word_ready_i = 0, cmd_valid_i;
    logic [3:0] chan_i = 4'h0;
    logic cmd_ready_o, trigger_o, busy_o, counting_o, lost_o, word_valid_o;
    ctw_pkg::ctw_cmd_t  cmd_i;
    ctw_pkg::ctw_word_t word_o;
    int err_total, cmp_count, trig_n, edge_n, exp_trig, base, sc[4];
    bit run;
    logic [31:0] expq[$];
    logic [31:0] rnd = 32'hF2DC;
    ctw_core u_ctw_core (.clock_i, .rst_i, .ce_i, .chan_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
        .trigger_o, .busy_o, .counting_o, .lost_o, .word_valid_o, .word_o, .word_ready_i);
    ctw_host_model u_ctw_host_model (.clock_i, .cmd_ready_i(cmd_ready_o),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
    initial
    forever #5 clock_i = ~clock_i;
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic hs(input ctw_pkg::ctw_op_t op, input logic [7:0] idx, val);
        u_ctw_host_model.send(op, idx, val);
    endtask
    // channels in m rise gap cycles apart, in index order
    task automatic pulses(input logic [3:0] m, input int gap, input int trig);
        for (int i = 0; i < 4; i++)
            if (m[i])
            begin
                chan_i[i] <= 1'b1;
                sc[i] += run;
                repeat (gap) @(posedge clock_i);
            end
        repeat (6) @(posedge clock_i);
        chan_i <= 4'h0;
        repeat (60) @(posedge clock_i);
        exp_trig += trig;
        check("triggers", trig_n, exp_trig);
        $display("pulse test done, mask %h", m);
    endtask
    task automatic display();
        for (int i = 0; i < 4; i++)
            expq.push_back({ctw_pkg::KIND_SCALER, 9'(i), 21'(sc[i])});
        expq.push_back({ctw_pkg::KIND_COINC, 9'h004, 21'(exp_trig - base)});
        hs(ctw_pkg::OP_DISPLAY, 8'h00, 8'h00);
        for (int i = 0; i < 300 && expq.size() > 0; i++) @(posedge clock_i);
        check("report drained", expq.size(), 0);
        $display("display test done");
    endtask
    // ****************
    // monitor and sequence
    // ****************
    always @(posedge clock_i)
    begin
        word_ready_i <= (xs() & 32'h3) != 32'h0;
        if (trigger_o === 1'b1)
            trig_n++;
        if (word_valid_o === 1'b1 && word_ready_i === 1'b1)
            if (word_o.kind === ctw_pkg::KIND_EDGE)
                edge_n++;
            else
                check("report word", word_o, expq.size() ? expq.pop_front() : 'x);
    end
    initial
    begin
        #200000;
        err_total++;
        final_report();
    end
    initial
    begin
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        run = 1;
        @(posedge clock_i);
        check("counting", counting_o, 1);
        display();
        pulses(4'h3, 4, 1);
        check("edge words", edge_n != 0, 1);
        hs(ctw_pkg::OP_WTIME, 8'h01, 8'h01);
        hs(ctw_pkg::OP_WTIME, 8'h02, 8'h03);
        pulses(4'h3, 30, 0);
        pulses(4'h3, 3, 1);
        hs(ctw_pkg::OP_WCTRL, 8'h00, 8'h2F);
        pulses(4'h3, 3, 0);
        pulses(4'h7, 2, 1);
        hs(ctw_pkg::OP_WCTRL, 8'h00, 8'h01);
        pulses(4'h2, 4, 0);
        pulses(4'h1, 4, 1);
        display();
        hs(ctw_pkg::OP_DISABLE, 8'h00, 8'h00);
        run = 0;
        check("counting", counting_o, 0);
        pulses(4'h1, 4, 0);
        display();
        hs(ctw_pkg::OP_ENABLE, 8'h00, 8'h00);
        run = 1;
        check("counting", counting_o, 1);
        hs(ctw_pkg::OP_WCTRL, 8'h02, 8'h00);
        hs(ctw_pkg::OP_WCTRL, 8'h03, 8'h01);
        chan_i[0] <= 1'b1;
        sc[0]++;
        exp_trig++;
        repeat (200) @(posedge clock_i);
        check("busy wide", busy_o, 1);
        chan_i <= 4'h0;
        for (int i = 0; i < 1000 && busy_o !== 1'b0; i++) @(posedge clock_i);
        check("busy end", busy_o, 0);
        hs(ctw_pkg::OP_RESET, 8'h00, 8'h00);
        sc = '{default: 0};
        base = exp_trig;
        display();
        pulses(4'h3, 12, 1);
        display();
        check("lost", lost_o, 0);
        final_report();
    end
endmodule
